// file: rtl/fsi_status_indicator.sv
// Status indicator logic: network, block, expansion bus and channel lamps.
// Assumes all status inputs are synchronous levels from the node's logic.
// Contract
// - One lamp per channel, lit when active.
// - Green network lamp follows protocol state.
// - Red dark normally, blinks on bad configuration.
// - Error passive gives single red flash.
// - Guard or heartbeat event gives double flash.
// - Sync timeout gives triple red flash.
// - Process data timeout gives quadruple flash.
// - Bus off lights red steadily.
// - Erase ready blinks green 100/400 for 5s.
// - Booted steady green; dark without supply.
// - Bit-rate detection alternates green and red.
// - Erase confirm: two red flashes, gap.
// - Fixed bit-rate confirm: three red flashes.
// - Bad switch selection blinks red 400/800.
// - Block I/O error lights steady red.
// - Expansion green lamp follows bus state.
// - Output short or overcurrent: single red flash.
// - Supply out of range: double red flash.
// - Error or reset lights expansion red.
// - Stored bit-rate confirmed by three flashes.
`timescale 1ns/1ps
module fsi_flash_gen
	import fsi_pkg::*;
#(
	parameter int unsigned FLASH = FLASH_MS,
	parameter int unsigned GAP = GAP_MS
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic tick,
	input wire logic [CNT_W-1:0] count,
	output logic lamp
);
	// Runs count flashes of FLASH ms on / FLASH ms off, last off stretched to GAP
	localparam logic [PHASE_W-1:0] FL = PHASE_W'(FLASH);
	localparam logic [PHASE_W-1:0] GP = PHASE_W'(GAP);

	logic [PHASE_W-1:0] ms_q;
	logic [CNT_W-1:0] idx_q;
	logic on_q;
	logic [CNT_W-1:0] idx_next_w;
	logic last_w;
	logic [PHASE_W-1:0] limit_w;
	logic phase_end_w;

	assign idx_next_w = idx_q + CNT_W'(1);
	assign last_w = idx_next_w >= count;
	assign limit_w = on_q ? FL : (last_w ? GP : FL);
	// Phase ends on the tick that completes it, so each phase lasts whole ticks
	assign phase_end_w = tick && (ms_q + PHASE_W'(1) >= limit_w);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ms_q <= '0;
			idx_q <= '0;
			on_q <= 1'b1;
			lamp <= 1'b0;
		end else begin
			lamp <= on_q && (count != '0);
			if (count == '0) begin
				ms_q <= '0;
				idx_q <= '0;
				on_q <= 1'b1;
			end else if (phase_end_w) begin
				ms_q <= '0;
				on_q <= !on_q;
				if (!on_q) begin
					idx_q <= last_w ? '0 : idx_next_w;
				end
			end else if (tick) begin
				ms_q <= ms_q + PHASE_W'(1);
			end
		end
	end
endmodule

module fsi_lamp_flop (
	input wire logic clk,
	input wire logic resetn,
	input wire logic lit,
	output logic lamp
);
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			lamp <= 1'b0;
		end else begin
			lamp <= lit;
		end
	end
endmodule

module fsi_status_indicator
	import fsi_pkg::*;
#(
	parameter int unsigned CHANNELS = CH_COUNT,
	parameter int unsigned MS_DIV = MS_CYCLES
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [CHANNELS-1:0] channel_active,
	input wire logic [1:0] net_state,
	input wire logic cfg_invalid,
	input wire logic err_passive,
	input wire logic guard_event,
	input wire logic sync_timeout,
	input wire logic process_data_object_timeout,
	input wire logic bus_off,
	input wire logic supply_ok,
	input wire logic boot_done,
	input wire logic erase_ready,
	input wire logic bitrate_detect,
	input wire logic erase_confirm,
	input wire logic bitrate_stored,
	input wire logic switch_invalid,
	input wire logic block_io_error,
	input wire logic [1:0] xbus_state,
	input wire logic out_short,
	input wire logic io_supply_bad,
	input wire logic xblock_error,
	input wire logic xblock_reset,
	output logic [CHANNELS-1:0] channel_lamp,
	output logic net_green,
	output logic net_red,
	output logic blk_green,
	output logic blk_red,
	output logic xbus_green,
	output logic xblk_red
);
	localparam int unsigned DIV_W = $clog2(MS_DIV + 1);
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MS_DIV - 1);
	localparam logic [PHASE_W-1:0] ERASE_LAST = PHASE_W'(ERASE_TOTAL_MS - 1);
	logic [DIV_W-1:0] div_q;
	logic tick_q;
	logic div_wrap_w;

	assign div_wrap_w = (div_q == DIV_LAST);
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			div_q <= '0;
			tick_q <= 1'b0;
		end else begin
			tick_q <= div_wrap_w;
			div_q <= div_wrap_w ? '0 : div_q + DIV_W'(1);
		end
	end

	// Channel lamps are one flop behind the channel state
	for (genvar c = 0; c < CHANNELS; c++) begin : g_chan
		fsi_lamp_flop u_lamp (
			.clk(clk),
			.resetn(resetn),
			.lit(channel_active[c]),
			.lamp(channel_lamp[c])
		);
	end

	// State decodes shared by the lamp selection
	logic net_is_preop_w;
	logic net_is_stop_w;
	logic net_is_fwupd_w;
	logic net_is_oper_w;
	logic xb_is_reset_w;
	logic xb_is_preop_w;
	logic xb_is_oper_w;
	assign net_is_preop_w = (net_state == NET_PREOP);
	assign net_is_stop_w = (net_state == NET_STOP);
	assign net_is_fwupd_w = (net_state == NET_FWUPD);
	assign net_is_oper_w = (net_state == NET_OPER);
	assign xb_is_reset_w = (xbus_state == XB_RESET);
	assign xb_is_preop_w = (xbus_state == XB_PREOP);
	assign xb_is_oper_w = (xbus_state == XB_OPER);

	// Shared pattern generators
	logic blink200_w;
	logic blink_erase_w;
	logic blink_sw_w;
	logic net_g_flash_w;
	logic net_r_flash_w;
	logic blk_r_flash_w;
	logic xb_flash_w;
	logic xr_flash_w;
	logic [CNT_W-1:0] net_g_cnt_w;
	logic [CNT_W-1:0] net_r_cnt_w;
	logic [CNT_W-1:0] blk_r_cnt_w;
	logic [CNT_W-1:0] xb_cnt_w;
	logic [CNT_W-1:0] xr_cnt_w;
	logic erase_active_w;

	// Equal on and off with a count of one is a plain blink
	fsi_flash_gen #(.FLASH(FLASH_MS), .GAP(FLASH_MS)) u_blink200 (
		.clk(clk),
		.resetn(resetn),
		.tick(tick_q),
		.count(N_ONE),
		.lamp(blink200_w)
	);
	fsi_flash_gen #(.FLASH(ERASE_ON_MS), .GAP(ERASE_OFF_MS)) u_blink_erase (
		.clk(clk),
		.resetn(resetn),
		.tick(tick_q),
		.count(erase_active_w ? N_ONE : CNT_W'(0)),
		.lamp(blink_erase_w)
	);
	fsi_flash_gen #(.FLASH(SWERR_ON_MS), .GAP(SWERR_OFF_MS)) u_blink_sw (
		.clk(clk),
		.resetn(resetn),
		.tick(tick_q),
		.count(switch_invalid ? N_ONE : CNT_W'(0)),
		.lamp(blink_sw_w)
	);

	assign net_g_cnt_w = net_is_stop_w ? N_ONE :
		net_is_fwupd_w ? N_THREE : CNT_W'(0);
	fsi_flash_gen u_net_g (
		.clk(clk),
		.resetn(resetn),
		.tick(tick_q),
		.count(net_g_cnt_w),
		.lamp(net_g_flash_w)
	);

	// Severity order: process data, sync, guard, passive; bus off overrides all
	assign net_r_cnt_w = process_data_object_timeout ? N_FOUR :
		sync_timeout ? N_THREE :
		guard_event ? N_TWO :
		err_passive ? N_ONE : CNT_W'(0);
	fsi_flash_gen u_net_r (
		.clk(clk),
		.resetn(resetn),
		.tick(tick_q),
		.count(net_r_cnt_w),
		.lamp(net_r_flash_w)
	);

	assign blk_r_cnt_w = bitrate_stored ? N_THREE :
		erase_confirm ? N_TWO : CNT_W'(0);
	fsi_flash_gen u_blk_r (
		.clk(clk),
		.resetn(resetn),
		.tick(tick_q),
		.count(blk_r_cnt_w),
		.lamp(blk_r_flash_w)
	);

	assign xb_cnt_w = xb_is_reset_w ? N_ONE : CNT_W'(0);
	fsi_flash_gen u_xb (
		.clk(clk),
		.resetn(resetn),
		.tick(tick_q),
		.count(xb_cnt_w),
		.lamp(xb_flash_w)
	);

	assign xr_cnt_w = io_supply_bad ? N_TWO : out_short ? N_ONE : CNT_W'(0);
	fsi_flash_gen u_xr (
		.clk(clk),
		.resetn(resetn),
		.tick(tick_q),
		.count(xr_cnt_w),
		.lamp(xr_flash_w)
	);

	// Erase window: 5 s from the rising edge of erase_ready, then hold off
	fsi_erase_t er_q;
	logic [PHASE_W-1:0] er_ms_q;
	logic er_done_w;
	assign erase_active_w = (er_q == FSI_ST_RUN);
	assign er_done_w = tick_q && (er_ms_q == ERASE_LAST);
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			er_q <= FSI_ST_IDLE;
			er_ms_q <= '0;
		end else begin
			case (er_q)
				FSI_ST_IDLE: begin
					er_ms_q <= '0;
					if (erase_ready) er_q <= FSI_ST_RUN;
				end
				FSI_ST_RUN: begin
					if (!erase_ready) er_q <= FSI_ST_IDLE;
					else if (er_done_w) er_q <= FSI_ST_DONE;
					else if (tick_q) er_ms_q <= er_ms_q + PHASE_W'(1);
				end
				FSI_ST_DONE: begin
					if (!erase_ready) er_q <= FSI_ST_IDLE;
				end
				default: er_q <= FSI_ST_IDLE;
			endcase
		end
	end

	// Lamp selection
	logic net_g_w;
	logic net_r_w;
	logic blk_g_w;
	logic blk_r_w;
	logic xb_g_w;
	logic xr_w;
	logic net_r_flashing_w;
	logic blk_r_flashing_w;
	logic blk_g_blocked_w;
	assign net_r_flashing_w = (net_r_cnt_w != '0);
	assign blk_r_flashing_w = (blk_r_cnt_w != '0);
	// Any red display on the block lamp except bit-rate detection keeps its green half dark
	assign blk_g_blocked_w = block_io_error || switch_invalid || blk_r_flashing_w;
	assign net_g_w = net_is_oper_w ? 1'b1 :
		net_is_preop_w ? blink200_w : net_g_flash_w;
	assign net_r_w = bus_off ? 1'b1 :
		net_r_flashing_w ? net_r_flash_w :
		cfg_invalid ? blink200_w : 1'b0;
	// Block lamp: errors win over confirmations, those over start-up displays
	assign blk_r_w = !supply_ok ? 1'b0 :
		block_io_error ? 1'b1 :
		switch_invalid ? blink_sw_w :
		blk_r_flashing_w ? blk_r_flash_w :
		bitrate_detect ? !blink200_w : 1'b0;
	assign blk_g_w = !supply_ok ? 1'b0 :
		blk_g_blocked_w ? 1'b0 :
		bitrate_detect ? blink200_w :
		erase_active_w ? blink_erase_w :
		(er_q == FSI_ST_DONE) ? 1'b0 :
		boot_done;
	assign xb_g_w = xb_is_oper_w ? 1'b1 :
		xb_is_preop_w ? blink200_w : xb_flash_w;
	assign xr_w = (xblock_error || xblock_reset) ? 1'b1 : xr_flash_w;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			net_green <= 1'b0;
			net_red <= 1'b0;
			blk_green <= 1'b0;
			blk_red <= 1'b0;
			xbus_green <= 1'b0;
			xblk_red <= 1'b0;
		end else begin
			net_green <= net_g_w;
			net_red <= net_r_w;
			blk_green <= blk_g_w;
			blk_red <= blk_r_w;
			xbus_green <= xb_g_w;
			xblk_red <= xr_w;
		end
	end
endmodule

// file: rtl/fsi_pkg.sv
// Constants for the field-bus I/O status indicator block.
// Assumes a single system clock; timing counts derive from its rate.
package fsi_pkg;
	localparam int unsigned CLK_HZ = 250_000_000;
	localparam int unsigned TICK_HZ = 1000;
	localparam int unsigned MS_CYCLES = CLK_HZ / TICK_HZ;
	localparam int unsigned CH_COUNT = 8;
	// Times in milliseconds, then counter widths in bits
	localparam int unsigned FLASH_MS = 200;
	localparam int unsigned GAP_MS = 1000;
	localparam int unsigned ERASE_ON_MS = 100;
	localparam int unsigned ERASE_OFF_MS = 400;
	localparam int unsigned ERASE_TOTAL_MS = 5000;
	localparam int unsigned SWERR_ON_MS = 400;
	localparam int unsigned SWERR_OFF_MS = 800;
	localparam int unsigned PHASE_W = 13;
	localparam int unsigned CNT_W = 3;
	// Network protocol state encoding
	localparam logic [1:0] NET_PREOP = 2'h0;
	localparam logic [1:0] NET_STOP = 2'h1;
	localparam logic [1:0] NET_FWUPD = 2'h2;
	localparam logic [1:0] NET_OPER = 2'h3;
	// Expansion bus state encoding
	localparam logic [1:0] XB_RESET = 2'h0;
	localparam logic [1:0] XB_PREOP = 2'h1;
	localparam logic [1:0] XB_OPER = 2'h2;
	// Flash counts
	localparam logic [CNT_W-1:0] N_ONE = 3'h1;
	localparam logic [CNT_W-1:0] N_TWO = 3'h2;
	localparam logic [CNT_W-1:0] N_THREE = 3'h3;
	localparam logic [CNT_W-1:0] N_FOUR = 3'h4;
	typedef enum logic [2:0] {
		FSI_ST_IDLE = 3'b001,
		FSI_ST_RUN = 3'b010,
		FSI_ST_DONE = 3'b100
	} fsi_erase_t;
endpackage

// file: tb/fsi_status_checker.sv
// Checker for the steady lamp relations of fsi_status_indicator.
// Assumes it is bound to the top module and that inputs are levels.
`timescale 1ns/1ps
module fsi_status_checker
	import fsi_pkg::*;
#(
	parameter int unsigned CHANNELS = CH_COUNT
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [CHANNELS-1:0] channel_active,
	input wire logic [CHANNELS-1:0] channel_lamp,
	input wire logic [1:0] net_state,
	input wire logic net_green,
	input wire logic bus_off,
	input wire logic net_red,
	input wire logic supply_ok,
	input wire logic block_io_error,
	input wire logic blk_green,
	input wire logic blk_red,
	input wire logic [1:0] xbus_state,
	input wire logic xbus_green,
	input wire logic xblock_error,
	input wire logic xblock_reset,
	input wire logic xblk_red
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// Four cycles leave room for the registered output stage
	sequence s_held(c);
		c[*4];
	endsequence
	a_chan_follow: assert property ($past(resetn) |-> channel_lamp == $past(channel_active))
		else $error("channel lamp not following activity");
	a_bus_off_red: assert property (s_held(bus_off) |-> net_red)
		else $error("bus off lamp dark");
	a_oper_green: assert property (s_held(net_state == NET_OPER) |-> net_green)
		else $error("operational green dark");
	a_nosupply_dark: assert property (s_held(!supply_ok) |-> !blk_green && !blk_red)
		else $error("block lamp lit without supply");
	a_io_error_red: assert property (s_held(supply_ok && block_io_error) |-> blk_red && !blk_green)
		else $error("block error not steady red");
	a_xbus_oper: assert property (s_held(xbus_state == XB_OPER) |-> xbus_green)
		else $error("expansion green dark when operational");
	a_xbus_dark: assert property (s_held(xbus_state == 2'h3) |-> !xbus_green)
		else $error("expansion green lit in dark state");
	a_xblk_error: assert property (s_held(xblock_error || xblock_reset) |-> xblk_red)
		else $error("expansion red dark on error");
endmodule

bind fsi_status_indicator fsi_status_checker #(.CHANNELS(CHANNELS)) i_fsi_status_checker (.*);

// file: tb/fsi_node_model.sv
// Model of the network master and expansion bus status seen by the node.
// Assumes mode is changed by the bench at the falling clock edge.
`timescale 1ns/1ps
module fsi_node_model
	import fsi_pkg::*;
(
	input wire logic [3:0] mode,
	output logic [1:0] net_state,
	output logic cfg_invalid,
	output logic err_passive,
	output logic guard_event,
	output logic sync_timeout,
	output logic data_late,
	output logic bus_off,
	output logic [1:0] xbus_state,
	output logic xblock_error,
	output logic xblock_reset
);
	// Mode 1 raises every net fault except cfg_invalid at once so ranking is exercised
	assign net_state = mode == 4'h9 ? NET_STOP : mode == 4'hA ? NET_FWUPD : NET_OPER;
	assign bus_off = mode == 4'h1;
	assign err_passive = mode == 4'h4 || bus_off;
	assign guard_event = mode == 4'h5 || mode == 4'h7 || bus_off;
	assign sync_timeout = mode == 4'h6 || bus_off;
	assign data_late = mode == 4'h7 || bus_off;
	assign cfg_invalid = mode == 4'h8;
	assign xbus_state = (mode == 4'h2 || mode == 4'h3) ? 2'h3 : XB_OPER;
	assign xblock_error = mode == 4'h2;
	assign xblock_reset = mode == 4'h3;
endmodule

// file: tb/fsi_status_indicator_bench.sv
// Self-checking bench for fsi_status_indicator with a short ms tick.
// Assumes fsi_node_model drives the network and expansion inputs except out_short and io_supply_bad.
`timescale 1ns/1ps
module fsi_status_indicator_bench;
	import fsi_pkg::*;
	localparam int DIV = 1;
	typedef struct packed {logic [3:0] m; logic [2:0] b; logic [7:0] ch; logic [5:0] exp;} fsi_row_t;
	logic clk = 1'b0, resetn = 1'b0, sup = 1'b0, boot = 1'b0, ioerr = 1'b0;
	logic swbad = 1'b0, econf = 1'b0, bstore = 1'b0, probe;
	logic detect = 1'b0, erase = 1'b0, oshort = 1'b0, iobad = 1'b0;
	logic [7:0] chan = 8'h00, lamp;
	logic [3:0] mode = 4'h0;
	logic [1:0] ns, xs;
	logic ci, ep, ge, st, dl, bo, xe, xrs, ng, nr, bg, br, xg, xl;
	int n_mismatch = 0, n_compared = 0, sel = 0;
	fsi_row_t rows [4] = '{'{4'h0, 3'h6, 8'hA5, 6'h2A}, '{4'h1, 3'h7, 8'h5A, 6'h36},
		'{4'h2, 3'h3, 8'hFF, 6'h21}, '{4'h3, 3'h4, 8'h00, 6'h21}};
	assign probe = sel == 0 ? nr : sel == 1 ? ng : sel == 2 ? br : sel == 3 ? bg : xl;
	fsi_node_model i_fsi_node_model (.mode(mode), .net_state(ns), .cfg_invalid(ci), .err_passive(ep),
		.guard_event(ge), .sync_timeout(st), .data_late(dl), .bus_off(bo), .xbus_state(xs),
		.xblock_error(xe), .xblock_reset(xrs));
	fsi_status_indicator #(.MS_DIV(DIV)) i_fsi_status_indicator (.clk(clk), .resetn(resetn),
		.channel_active(chan), .net_state(ns), .cfg_invalid(ci), .err_passive(ep), .guard_event(ge),
		.sync_timeout(st), .process_data_object_timeout(dl), .bus_off(bo), .supply_ok(sup),
		.boot_done(boot), .erase_ready(erase), .bitrate_detect(detect), .erase_confirm(econf),
		.bitrate_stored(bstore), .switch_invalid(swbad), .block_io_error(ioerr), .xbus_state(xs),
		.out_short(oshort), .io_supply_bad(iobad), .xblock_error(xe), .xblock_reset(xrs),
		.channel_lamp(lamp), .net_green(ng), .net_red(nr), .blk_green(bg), .blk_red(br),
		.xbus_green(xg), .xblk_red(xl));
	initial begin
		forever #2 clk = ~clk;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic stop_test();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// Caps keep a stuck lamp from hanging the loop
	task automatic measure(output int hi, output int lo);
		hi = 0;
		lo = 0;
		while (probe !== 1'b1 && hi < 30000) begin @(negedge clk); hi++; end
		hi = 0;
		while (probe === 1'b1 && hi < 30000) begin @(negedge clk); hi++; end
		while (probe !== 1'b1 && lo < 30000) begin @(negedge clk); lo++; end
	endtask
	task automatic flashes(input int n, input int on, input int gap);
		int hi, lo, k;
		k = 0;
		lo = 0;
		while (lo != gap * DIV && k < 8) begin measure(hi, lo); k++; end
		for (int i = 0; i < n; i++) begin
			measure(hi, lo);
			check(16'(hi), 16'(on * DIV));
			check(16'(lo), 16'((i == n - 1 ? gap : FLASH_MS) * DIV));
		end
		$display("test done: %0d flashes of %0d ms", n, on);
	endtask
	task automatic net_case(input logic [3:0] m, input int n, input int gap);
		@(negedge clk) mode = m;
		flashes(n, FLASH_MS, gap);
	endtask
	initial begin
		repeat (10) @(negedge clk);
		resetn = 1'b1;
		foreach (rows[i]) begin
			@(negedge clk) {mode, sup, boot, ioerr, chan} = {rows[i].m, rows[i].b, rows[i].ch};
			repeat (5) @(negedge clk);
			check({lamp, ng, nr, bg, br, xg, xl, 2'h0}, {rows[i].ch, rows[i].exp, 2'h0});
			$display("test done: row %0d", i);
		end
		net_case(4'h4, 1, GAP_MS);
		net_case(4'h5, 2, GAP_MS);
		net_case(4'h6, 3, GAP_MS);
		net_case(4'h7, 4, GAP_MS);
		net_case(4'h8, 1, FLASH_MS);
		sel = 1;
		net_case(4'h9, 1, GAP_MS);
		net_case(4'hA, 3, GAP_MS);
		sel = 2;
		@(negedge clk) {sup, boot, ioerr, swbad} = 4'hD;
		flashes(1, SWERR_ON_MS, SWERR_OFF_MS);
		@(negedge clk) {swbad, bstore} = 2'h1;
		flashes(3, FLASH_MS, GAP_MS);
		@(negedge clk) {bstore, econf} = 2'h1;
		flashes(2, FLASH_MS, GAP_MS);
		sel = 3;
		@(negedge clk) {econf, detect} = 2'h1;
		flashes(1, FLASH_MS, FLASH_MS);
		@(negedge clk) {detect, erase} = 2'h1;
		flashes(1, ERASE_ON_MS, ERASE_OFF_MS);
		sel = 4;
		@(negedge clk) {erase, oshort} = 2'h1;
		flashes(1, FLASH_MS, GAP_MS);
		@(negedge clk) {oshort, iobad} = 2'h1;
		flashes(2, FLASH_MS, GAP_MS);
		@(negedge clk) resetn = 1'b0;
		@(negedge clk);
		check({lamp, ng, nr, bg, br, xg, xl, 2'h0}, 16'h0000);
		$display("test done: mid-run reset");
		stop_test();
	end
	initial begin
		// Tests need about 39k cycles at one ms tick per cycle
		repeat (80000) @(posedge clk);
		n_mismatch++;
		stop_test();
	end
endmodule
